//--- logic/flags_ip_size_attributes.sv
`timescale 1ns/1ns
module flags_ip_size_attributes
  import flags_pkg::*;
#(
  parameter logic FEATURE_QUERY_SUPPORTED = 1'b1
)
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        RETIRE_I,
  input  wire logic [3:0]  OP_I,
  input  wire logic [3:0]  LENGTH_I,
  input  wire logic [63:0] TARGET_I,
  input  wire logic [31:0] POP_FLAGS_I,
  input  wire logic [31:0] DISP_I,
  input  wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL_I,
  input  wire logic [1:0]  MODE_I,
  input  wire logic        CS_DEFAULT_32_I,
  input  wire logic        PREFIX_OPERAND_I,
  input  wire logic        PREFIX_ADDRESS_I,
  input  wire logic        ALIGN_MASK_ENABLE_I,
  input  wire logic        USER_ACCESS_PREVENT_I,
  input  wire logic        VIRT_MODE_EXT_I,
  input  wire logic        INTR_REQ_I,
  input  wire logic        DEBUG_EXC_I,
  output logic      [63:0] FLAGS_O,
  output logic             STRING_DECREMENT_O,
  output logic             SINGLE_STEP_TRAP_O,
  output logic             INTR_TAKE_O,
  output logic             IO_ACCESS_OK_O,
  output logic             DEBUG_EXC_TAKE_O,
  output logic             VIRTUAL_MODE_O,
  output logic             ALIGN_CHECK_EN_O,
  output logic             SUPV_USER_ACCESS_OK_O,
  output logic             VIRT_INTR_SIGNAL_O,
  output logic             OPERAND_32_O,
  output logic             ADDRESS_32_O,
  output logic      [63:0] OFFSET_O,
  output logic      [63:0] RETURN_PTR_O,
  output logic      [63:0] REL_ADDR_O
);

  retire_op_t  op;
  logic [31:0] flags;
  logic        step_trap;
  wire  [31:0] next_flags;
  wire  [31:0] pop_mask;
  wire  [31:0] int_ret_mask;
  wire  [31:0] load_mask;
  wire         at_kernel;
  wire         do_pop;
  wire         do_int_ret;
  wire         string_dir;
  wire         single_step;
  wire         intr_accept;
  wire         debug_resume;
  wire         virt_mode;
  wire         align_flag;
  wire         virt_intr;
  wire         virt_pending;
  wire  [1:0]  io_priv;

  size_attr_if attr ();

  assign op = retire_op_t'(OP_I);

  // Field views of the flags register
  assign string_dir   = flags[POS_STRING_DIR];
  assign single_step  = flags[POS_SINGLE_STEP];
  assign intr_accept  = flags[POS_INTR_ACCEPT];
  assign debug_resume = flags[POS_DEBUG_RESUME];
  assign virt_mode    = flags[POS_VIRT_MODE];
  assign align_flag   = flags[POS_ALIGN_CHECK];
  assign virt_intr    = flags[POS_VIRT_INTR];
  assign virt_pending = flags[POS_VIRT_PENDING];
  assign io_priv      = flags[POS_IO_PRIV_HI:POS_IO_PRIV_LO];

  // Which bits a pop or interrupt return may load
  assign at_kernel    = (CURRENT_PRIVILEGE_LEVEL_I == KERNEL_LEVEL);
  assign do_pop       = RETIRE_I && (op == OP_FLAGS_POP);
  assign do_int_ret   = RETIRE_I && (op == OP_INT_RET);
  assign pop_mask     = (POP_MASK & ~(at_kernel ? 32'h0000_0000 : IO_PRIV_MASK))
                        & ~(FEATURE_QUERY_SUPPORTED ? 32'h0000_0000 : FEATURE_QRY_MASK);
  assign int_ret_mask = pop_mask | (at_kernel ? RET_EXTRA_MASK : 32'h0000_0000);
  assign load_mask    = do_int_ret ? int_ret_mask : (do_pop ? pop_mask : 32'h0000_0000);

  // Next flags value from the retiring operation
  function automatic logic [31:0] step_flags(input logic [31:0] cur, input logic [31:0] mask,
                                             input logic [31:0] src, input retire_op_t kind,
                                             input logic valid);
    logic [31:0] res;
    res = (cur & ~mask) | (src & mask);
    if (valid) begin
      unique case (kind)
        OP_SET_DIR:   res[POS_STRING_DIR]  = 1'b1;
        OP_CLEAR_DIR: res[POS_STRING_DIR]  = 1'b0;
        OP_TASK_LINK: res[POS_NESTED_TASK] = 1'b1;
        OP_TASK_FREE: res[POS_NESTED_TASK] = 1'b0;
        OP_PLAIN, OP_JUMP, OP_CALL, OP_RETURN: res[POS_DEBUG_RESUME] = 1'b0;
        default: res = res;
      endcase
    end
    res = (res & ~FLAGS_RESET & 32'h003F_7FFD) | FLAGS_RESET;
    step_flags = res;
  endfunction : step_flags

  assign next_flags = step_flags(flags, load_mask, POP_FLAGS_I, op, RETIRE_I);

  // Flags register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Single-step trap after each retired instruction while stepping
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step_trap <= 1'b0;
    end else begin
      step_trap <= RETIRE_I && single_step;
    end
  end

  // Size attribute resolution
  assign attr.mode           = cpu_mode_t'(MODE_I);
  assign attr.virt_mode      = virt_mode;
  assign attr.cs_default_32  = CS_DEFAULT_32_I;
  assign attr.prefix_operand = PREFIX_OPERAND_I;
  assign attr.prefix_address = PREFIX_ADDRESS_I;

  size_resolver u_size (
    .attr (attr.resolver)
  );

  offset_unit u_offset (
    .clk_i        (SYS_CLK_I),
    .rst_n_i      (RST_N_I),
    .retire_i     (RETIRE_I),
    .op_i         (op),
    .length_i     (LENGTH_I),
    .target_i     (TARGET_I),
    .disp_i       (DISP_I),
    .attr         (attr.consumer),
    .offset_o     (OFFSET_O),
    .return_ptr_o (RETURN_PTR_O),
    .rel_addr_o   (REL_ADDR_O)
  );

  // Gating outputs derived from the flags
  assign FLAGS_O               = {32'h0000_0000, flags};
  assign STRING_DECREMENT_O    = string_dir;
  assign SINGLE_STEP_TRAP_O    = step_trap;
  assign INTR_TAKE_O           = INTR_REQ_I && intr_accept;
  assign IO_ACCESS_OK_O        = (CURRENT_PRIVILEGE_LEVEL_I <= io_priv);
  assign DEBUG_EXC_TAKE_O      = DEBUG_EXC_I && !debug_resume;
  assign VIRTUAL_MODE_O        = virt_mode && (attr.mode == MODE_PROTECTED);
  assign ALIGN_CHECK_EN_O      = ALIGN_MASK_ENABLE_I && align_flag && (CURRENT_PRIVILEGE_LEVEL_I == USER_LEVEL);
  assign SUPV_USER_ACCESS_OK_O = !USER_ACCESS_PREVENT_I || align_flag;
  assign VIRT_INTR_SIGNAL_O    = VIRT_MODE_EXT_I && virt_intr && virt_pending;
  assign OPERAND_32_O          = attr.operand_32;
  assign ADDRESS_32_O          = attr.address_32;

endmodule : flags_ip_size_attributes

//--- logic/flags_pkg.sv
// Notes on behaviour
// - Set direction flag makes strings walk downward
// - Set/clear direction ops touch only that flag
// - Single-step traps while its flag is set
// - Maskable interrupts taken only with accept flag
// - I/O allowed when privilege level <= field
// - Pop/return change I/O field only at level 0
// - Nested task flag follows task link state
// - Resume flag suppresses debug exceptions
// - Virtual mode flag selects legacy virtual mode
// - Alignment check needs mask enable and flag
// - Supervisor user access allowed with flag or with prevention off
// - Virtual interrupt flag used only with extensions
// - Pending flag written by software only
// - Feature query flag writable when supported
// - Extended flags: upper half reserved zero
// - Offset advances by length, loads on transfers
// - Offset seen only via call, loaded via return
// - Long mode: 64-bit offset, relative addressing
// - Protected mode default size from segment flag
// - Real, virtual, management modes default 16-bit
// - Address size sets offset width and reach outside long mode
// - Prefixes toggle size for one instruction only
// - Reset loads flags with only bit 1 set
package flags_pkg;

  // Flag bit positions
  localparam int unsigned POS_RESERVED_ONE = 1;
  localparam int unsigned POS_SINGLE_STEP  = 8;
  localparam int unsigned POS_INTR_ACCEPT  = 9;
  localparam int unsigned POS_STRING_DIR   = 10;
  localparam int unsigned POS_IO_PRIV_LO   = 12;
  localparam int unsigned POS_IO_PRIV_HI   = 13;
  localparam int unsigned POS_NESTED_TASK  = 14;
  localparam int unsigned POS_DEBUG_RESUME = 16;
  localparam int unsigned POS_VIRT_MODE    = 17;
  localparam int unsigned POS_ALIGN_CHECK  = 18;
  localparam int unsigned POS_VIRT_INTR    = 19;
  localparam int unsigned POS_VIRT_PENDING = 20;
  localparam int unsigned POS_FEATURE_QRY  = 21;

  // Reset value and bits that pop and return may load
  localparam logic [31:0] FLAGS_RESET      = 32'h0000_0002;
  localparam logic [31:0] POP_MASK         = 32'h0024_7700;
  localparam logic [31:0] RET_EXTRA_MASK   = 32'h001B_0000;
  localparam logic [31:0] IO_PRIV_MASK     = 32'h0000_3000;
  localparam logic [31:0] FEATURE_QRY_MASK = 32'h0020_0000;

  // Offset masks per address size
  localparam logic [63:0] OFFSET_MASK_16   = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] OFFSET_MASK_32   = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] OFFSET_MASK_64   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] OFFSET_RESET     = 64'h0000_0000_0000_0000;

  // Least privileged level, used for user-mode accesses
  localparam logic [1:0]  USER_LEVEL       = 2'h3;
  localparam logic [1:0]  KERNEL_LEVEL     = 2'h0;

  // Retired operation classes
  typedef enum logic [3:0] {
    OP_PLAIN     = 4'h0,
    OP_SET_DIR   = 4'h1,
    OP_CLEAR_DIR = 4'h2,
    OP_FLAGS_POP = 4'h3,
    OP_INT_RET   = 4'h4,
    OP_JUMP      = 4'h5,
    OP_CALL      = 4'h6,
    OP_RETURN    = 4'h7,
    OP_TASK_LINK = 4'h8,
    OP_TASK_FREE = 4'h9
  } retire_op_t;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_REAL      = 2'h0,
    MODE_PROTECTED = 2'h1,
    MODE_SYS_MGMT  = 2'h2,
    MODE_LONG      = 2'h3
  } cpu_mode_t;

  // Address mask for a given size pair
  function automatic logic [63:0] offset_mask(input logic long_mode, input logic addr_32);
    if (long_mode) begin
      offset_mask = OFFSET_MASK_64;
    end else if (addr_32) begin
      offset_mask = OFFSET_MASK_32;
    end else begin
      offset_mask = OFFSET_MASK_16;
    end
  endfunction : offset_mask

endpackage : flags_pkg

//--- logic/size_attr_if.sv
`timescale 1ns/1ns
interface size_attr_if;
  import flags_pkg::*;
  cpu_mode_t   mode;
  logic        virt_mode;
  logic        cs_default_32;
  logic        prefix_operand;
  logic        prefix_address;
  logic        operand_32;
  logic        address_32;
  logic [63:0] mask;

  modport resolver (
    input  mode, virt_mode, cs_default_32, prefix_operand, prefix_address,
    output operand_32, address_32, mask
  );
  modport consumer (
    input  mode, operand_32, address_32, mask
  );
endinterface : size_attr_if

//--- logic/size_resolver.sv
`timescale 1ns/1ns
module size_resolver
  import flags_pkg::*;
(
  size_attr_if.resolver attr
);

  wire long_mode;
  wire protected_32;
  wire default_32;

  // Default size from mode and code segment flag
  assign long_mode    = (attr.mode == MODE_LONG);
  assign protected_32 = (attr.mode == MODE_PROTECTED) && !attr.virt_mode && attr.cs_default_32;
  assign default_32   = protected_32 || long_mode;

  // Prefixes flip the size of the current instruction only
  assign attr.operand_32 = default_32 ^ attr.prefix_operand;
  assign attr.address_32 = default_32 ^ attr.prefix_address;
  assign attr.mask       = offset_mask(long_mode, attr.address_32);

endmodule : size_resolver

//--- logic/offset_unit.sv
`timescale 1ns/1ns
module offset_unit
  import flags_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        retire_i,
  input  retire_op_t       op_i,
  input  wire logic [3:0]  length_i,
  input  wire logic [63:0] target_i,
  input  wire logic [31:0] disp_i,
  size_attr_if.consumer    attr,
  output logic      [63:0] offset_o,
  output logic      [63:0] return_ptr_o,
  output logic      [63:0] rel_addr_o
);

  logic [63:0] offset;
  logic [63:0] return_ptr;
  logic [63:0] rel_addr;
  wire  [63:0] next_seq;
  wire  [63:0] next_offset;
  wire         transfer;

  // Sequential successor, wrapped to the current address width
  assign next_seq    = (offset + {60'h0, length_i}) & attr.mask;
  assign transfer    = (op_i == OP_JUMP) || (op_i == OP_CALL) ||
                       (op_i == OP_RETURN) || (op_i == OP_INT_RET);
  assign next_offset = transfer ? (target_i & attr.mask) : next_seq;

  // Offset register, moved only by retirement
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset <= OFFSET_RESET;
    end else if (retire_i) begin
      offset <= next_offset;
    end
  end

  // Return pointer captured only by a call
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      return_ptr <= OFFSET_RESET;
    end else if (retire_i && (op_i == OP_CALL)) begin
      return_ptr <= next_seq;
    end
  end

  // Relative address from the end of the current instruction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rel_addr <= OFFSET_RESET;
    end else begin
      rel_addr <= (next_seq + {{32{disp_i[31]}}, disp_i}) & attr.mask;
    end
  end

  assign offset_o     = offset;
  assign return_ptr_o = return_ptr;
  assign rel_addr_o   = rel_addr;

endmodule : offset_unit

//--- bench/flags_ip_size_attributes_monitor.sv
`timescale 1ns/1ns
module flags_watch (
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        RETIRE_I,
  input wire logic [3:0]  OP_I,
  input wire logic [3:0]  LENGTH_I,
  input wire logic [63:0] TARGET_I,
  input wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL_I,
  input wire logic [1:0]  MODE_I,
  input wire logic        CS_DEFAULT_32_I,
  input wire logic        PREFIX_OPERAND_I,
  input wire logic        INTR_REQ_I,
  input wire logic [63:0] FLAGS_O,
  input wire logic        STRING_DECREMENT_O,
  input wire logic        SINGLE_STEP_TRAP_O,
  input wire logic        INTR_TAKE_O,
  input wire logic        IO_ACCESS_OK_O,
  input wire logic        OPERAND_32_O,
  input wire logic [63:0] OFFSET_O,
  input wire logic [63:0] RETURN_PTR_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Steps of a long-mode call: retire, then jump and return pointer
  sequence s_call;
    RETIRE_I && OP_I == 4'h6 && MODE_I == 2'h3;
  endsequence
  sequence s_loaded;
    OFFSET_O == $past(TARGET_I) && RETURN_PTR_O == $past(OFFSET_O) + $past(LENGTH_I);
  endsequence
  property p_dir; STRING_DECREMENT_O == FLAGS_O[10]; endproperty
  property p_set; RETIRE_I && OP_I == 4'h1 |=> FLAGS_O[10] && FLAGS_O[9:0] == $past(FLAGS_O[9:0]); endproperty
  property p_clr; RETIRE_I && OP_I == 4'h2 |=> !FLAGS_O[10] && FLAGS_O[9:0] == $past(FLAGS_O[9:0]); endproperty
  property p_step; RETIRE_I && FLAGS_O[8] |=> SINGLE_STEP_TRAP_O; endproperty
  property p_intr; INTR_TAKE_O == (INTR_REQ_I && FLAGS_O[9]); endproperty
  property p_io; IO_ACCESS_OK_O == (CURRENT_PRIVILEGE_LEVEL_I <= FLAGS_O[13:12]); endproperty
  property p_io_field;
    RETIRE_I && OP_I inside {4'h3, 4'h4} && CURRENT_PRIVILEGE_LEVEL_I != 2'h0
      |=> FLAGS_O[13:12] == $past(FLAGS_O[13:12]);
  endproperty
  property p_rsv; FLAGS_O[63:32] == 32'h0 && FLAGS_O[1]; endproperty
  property p_call; s_call |=> s_loaded; endproperty
  property p_size; MODE_I == 2'h1 && !FLAGS_O[17] |-> OPERAND_32_O == (CS_DEFAULT_32_I ^ PREFIX_OPERAND_I); endproperty
  property p_legacy; MODE_I inside {2'h0, 2'h2} |-> OPERAND_32_O == PREFIX_OPERAND_I; endproperty
  // Flag bits, privilege, offsets and size selection
  a_dir: assert property (p_dir) else $error("direction output off");
  a_set: assert property (p_set) else $error("set direction wrong");
  a_clr: assert property (p_clr) else $error("clear direction wrong");
  a_step: assert property (p_step) else $error("no single-step trap");
  a_intr: assert property (p_intr) else $error("interrupt take wrong");
  a_io: assert property (p_io) else $error("io permission wrong");
  a_io_field: assert property (p_io_field) else $error("io field changed");
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  a_call: assert property (p_call) else $error("call offsets wrong");
  a_size: assert property (p_size) else $error("protected size wrong");
  a_legacy: assert property (p_legacy) else $error("legacy size wrong");
endmodule : flags_watch

//--- bench/tb_flags_ip_size_attributes.sv
`timescale 1ns/1ns
module tb_flags_ip_size_attributes;
  logic SYS_CLK_I = 1'h0, RST_N_I = 1'h0, RETIRE_I = 1'h0;
  logic [3:0] OP_I = 4'h0, LENGTH_I = 4'h0;
  logic [63:0] TARGET_I = 64'h0;
  logic [31:0] POP_FLAGS_I = 32'h0, DISP_I = 32'h0;
  logic [1:0] CURRENT_PRIVILEGE_LEVEL_I = 2'h0, MODE_I = 2'h3;
  logic CS_DEFAULT_32_I = 1'h0, PREFIX_OPERAND_I = 1'h0, PREFIX_ADDRESS_I = 1'h0, ALIGN_MASK_ENABLE_I = 1'h0;
  logic USER_ACCESS_PREVENT_I = 1'h0, VIRT_MODE_EXT_I = 1'h0, INTR_REQ_I = 1'h0, DEBUG_EXC_I = 1'h0;
  wire logic [63:0] FLAGS_O, OFFSET_O, RETURN_PTR_O, REL_ADDR_O;
  wire logic STRING_DECREMENT_O, SINGLE_STEP_TRAP_O, INTR_TAKE_O, IO_ACCESS_OK_O, DEBUG_EXC_TAKE_O;
  wire logic VIRTUAL_MODE_O, ALIGN_CHECK_EN_O, SUPV_USER_ACCESS_OK_O, VIRT_INTR_SIGNAL_O, OPERAND_32_O, ADDRESS_32_O;
  int fails = 0, compares = 0, cycles = 0;
  // Permission and mode outputs gathered for one compare
  wire logic [6:0] side = {INTR_TAKE_O, IO_ACCESS_OK_O, ALIGN_CHECK_EN_O, SUPV_USER_ACCESS_OK_O,
                           VIRT_INTR_SIGNAL_O, DEBUG_EXC_TAKE_O, VIRTUAL_MODE_O};
  always #25 SYS_CLK_I = ~SYS_CLK_I;
  flags_ip_size_attributes dut (.SYS_CLK_I, .RST_N_I, .RETIRE_I, .OP_I, .LENGTH_I, .TARGET_I, .POP_FLAGS_I,
    .DISP_I, .CURRENT_PRIVILEGE_LEVEL_I, .MODE_I, .CS_DEFAULT_32_I, .PREFIX_OPERAND_I, .PREFIX_ADDRESS_I,
    .ALIGN_MASK_ENABLE_I, .USER_ACCESS_PREVENT_I, .VIRT_MODE_EXT_I, .INTR_REQ_I, .DEBUG_EXC_I, .FLAGS_O,
    .STRING_DECREMENT_O, .SINGLE_STEP_TRAP_O, .INTR_TAKE_O, .IO_ACCESS_OK_O, .DEBUG_EXC_TAKE_O, .VIRTUAL_MODE_O,
    .ALIGN_CHECK_EN_O, .SUPV_USER_ACCESS_OK_O, .VIRT_INTR_SIGNAL_O, .OPERAND_32_O, .ADDRESS_32_O, .OFFSET_O,
    .RETURN_PTR_O, .REL_ADDR_O);
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One retiring instruction, driven at the falling edge and taken at the rising edge
  task automatic ret(input logic [3:0] op, input logic [3:0] len, input logic [63:0] tg, input logic [31:0] pf);
    @(negedge SYS_CLK_I);
    {RETIRE_I, OP_I, LENGTH_I, TARGET_I, POP_FLAGS_I} = {1'h1, op, len, tg, pf};
    @(posedge SYS_CLK_I);
    @(negedge SYS_CLK_I);
    RETIRE_I = 1'h0;
  endtask : ret
  // Hang guard
  always @(posedge SYS_CLK_I) begin
    cycles++;
    if (cycles == 400) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(negedge SYS_CLK_I);
    RST_N_I = 1'h1;
    chk("flags", 64'h2, FLAGS_O);
    chk("offset", 64'h0, OFFSET_O);
    ret(4'h1, 4'h3, 64'h0, 32'h0);
    chk("flags", 64'h402, FLAGS_O);
    chk("strdec", 64'h1, {63'h0, STRING_DECREMENT_O});
    ret(4'h2, 4'h2, 64'h0, 32'h0);
    chk("flags", 64'h2, FLAGS_O);
    chk("offset", 64'h5, OFFSET_O);
    ret(4'h3, 4'h1, 64'h0, 32'hFFFF_FFFF);
    chk("flags", 64'h0024_7702, FLAGS_O);
    {CURRENT_PRIVILEGE_LEVEL_I, ALIGN_MASK_ENABLE_I, USER_ACCESS_PREVENT_I, INTR_REQ_I, DEBUG_EXC_I} = 6'h3F;
    #1 chk("side", 64'h7A, side);
    ret(4'h3, 4'h1, 64'h0, 32'h0);
    chk("flags", 64'h3002, FLAGS_O);
    chk("trap", 64'h1, {63'h0, SINGLE_STEP_TRAP_O});
    #1 chk("side", 64'h22, side);
    @(negedge SYS_CLK_I);
    for (int m = 0; m < 3; m++) for (int i = 0; i < 8; i++) begin
      MODE_I = m[1:0];
      {CS_DEFAULT_32_I, PREFIX_OPERAND_I, PREFIX_ADDRESS_I} = i[2:0];
      #1 chk("sizes", {62'h0, {2{m == 1 && i[2]}} ^ i[1:0]}, {62'h0, OPERAND_32_O, ADDRESS_32_O});
    end
    @(negedge SYS_CLK_I);
    {CURRENT_PRIVILEGE_LEVEL_I, MODE_I, VIRT_MODE_EXT_I, CS_DEFAULT_32_I, PREFIX_OPERAND_I, PREFIX_ADDRESS_I} = 8'h1C;
    ret(4'h4, 4'h2, 64'h100, 32'h001B_0000);
    chk("flags", 64'h001B_0002, FLAGS_O);
    chk("trap", 64'h0, {63'h0, SINGLE_STEP_TRAP_O});
    #1 chk("side", 64'h25, side);
    ret(4'h8, 4'h1, 64'h0, 32'h0);
    chk("flags", 64'h001B_4002, FLAGS_O);
    ret(4'h9, 4'h1, 64'h0, 32'h0);
    chk("flags", 64'h001B_0002, FLAGS_O);
    ret(4'h0, 4'h1, 64'h0, 32'h0);
    chk("flags", 64'h001A_0002, FLAGS_O);
    chk("offset", 64'h103, OFFSET_O);
    CS_DEFAULT_32_I = 1'h0;
    ret(4'h5, 4'h1, 64'h1_2345, 32'h0);
    chk("offset", 64'h2345, OFFSET_O);
    MODE_I = 2'h3;
    ret(4'h6, 4'h5, 64'h1234_5678_9ABC_DEF0, 32'h0);
    chk("offset", 64'h1234_5678_9ABC_DEF0, OFFSET_O);
    chk("retptr", 64'h234A, RETURN_PTR_O);
    {LENGTH_I, DISP_I} = {4'h4, 32'hFFFF_FFF0};
    @(posedge SYS_CLK_I);
    @(negedge SYS_CLK_I);
    chk("reladdr", 64'h1234_5678_9ABC_DEE4, REL_ADDR_O);
    ret(4'h7, 4'h1, 64'h234A, 32'h0);
    chk("offset", 64'h234A, OFFSET_O);
    tally_and_finish();
  end
endmodule : tb_flags_ip_size_attributes
bind flags_ip_size_attributes flags_watch mon (.SYS_CLK_I, .RST_N_I, .RETIRE_I, .OP_I, .LENGTH_I, .TARGET_I,
  .CURRENT_PRIVILEGE_LEVEL_I, .MODE_I, .CS_DEFAULT_32_I, .PREFIX_OPERAND_I, .INTR_REQ_I, .FLAGS_O,
  .STRING_DECREMENT_O, .SINGLE_STEP_TRAP_O, .INTR_TAKE_O, .IO_ACCESS_OK_O, .OPERAND_32_O, .OFFSET_O, .RETURN_PTR_O);
